// [design/cid_cfg.svh]
// constants for the instruction decode and execute block
`ifndef CID_CFG_SVH
`define CID_CFG_SVH
// instruction field positions
`define CID_SREG_LO     8
`define CID_AD_BIT      7
`define CID_BW_BIT      6
`define CID_AS_LO       4
`define CID_DREG_LO     0
`define CID_JCOND_LO    10
`define CID_JOFS_MSB    9
`define CID_SGL_SEL_LO  6
// format tags
`define CID_DUAL_MIN    4'h4
`define CID_JUMP_TAG    3'h1
`define CID_SGL_TAG     6'h04
// register numbers
`define CID_REG_PC      4'h0
`define CID_REG_SR      4'h2
`define CID_REG_CG2     4'h3
// status register bit positions
`define CID_SR_C        0
`define CID_SR_Z        1
`define CID_SR_N        2
`define CID_SR_V        8
// constant generator values and stack step
`define CID_CG_ZERO     16'h0000
`define CID_CG_ONE      16'h0001
`define CID_CG_TWO      16'h0002
`define CID_CG_FOUR     16'h0004
`define CID_CG_EIGHT    16'h0008
`define CID_CG_ONES     16'hffff
`define CID_STACK_STEP  16'h0002
// cycle counts
`define CID_CYC_SRC_REG  3'h1
`define CID_CYC_SRC_IND  3'h2
`define CID_CYC_SRC_IDX  3'h3
`define CID_CYC_PC_EXTRA 3'h1
`define CID_CYC_IDX_COPY 3'h2
`define CID_CYC_IDX_ALU  3'h3
`define CID_CYC_STK_REG  3'h3
`define CID_CYC_STK_IND  3'h4
`define CID_CYC_STK_IDX  3'h5
`define CID_CYC_SGL_REG  3'h1
`define CID_CYC_SGL_IND  3'h3
`define CID_CYC_SGL_IDX  3'h4
`define CID_CYC_JUMP     3'h2
`define CID_CYC_INTERRUPT_RETURN_OP     3'h3
`define CID_CYC_ILLEGAL  3'h1
`endif

// [design/cid_pkg.sv]
// types shared by the instruction decode and execute block
`default_nettype none
package cid_pkg;
  typedef enum logic [4:0] {
    copy_op, sum_op, sum_with_carry_op, difference_with_borrow_op, difference_op,
    compare_op, decimal_sum_op, mask_test_op, mask_clear_op, mask_set_op, xor_op,
    and_op, rotate_right_carry_op, byte_swap_op, shift_right_signed_op,
    sign_extend_op, push_op, call_op, interrupt_return_op, jump_op, illegal_op
  } cid_op_e;
  typedef enum logic [1:0] {
    st_idle = 2'h0, st_pop_status = 2'h1, st_pop_pc = 2'h3, st_store = 2'h2
  } cid_state_e;
  typedef struct packed {logic v; logic n; logic z; logic c;} cid_flags_s;
  typedef struct packed {
    logic        valid;
    logic [15:0] instr;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] src_val;
    logic [15:0] dst_val;
    cid_flags_s  flags;
  } cid_issue_s;
  typedef struct packed {
    logic        req;
    logic        we;
    logic        byte_op;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cid_mem_req_s;
  typedef struct packed {logic ack; logic [15:0] rdata;} cid_mem_rsp_s;
  typedef struct packed {
    logic        valid;
    logic        illegal;
    logic        byte_op;
    logic        src_const;
    logic        dst_wr;
    logic [3:0]  dst_reg;
    logic [15:0] result;
    logic        flag_wr;
    cid_flags_s  flags;
    logic        sr_wr;
    logic [15:0] sr;
    logic        pc_wr;
    logic [15:0] pc;
    logic        sp_wr;
    logic [15:0] sp;
    logic [2:0]  cycles;
  } cid_result_s;
endpackage
`default_nettype wire

// [design/cid_alu.sv]
// arithmetic and logic unit with status flag generation
`default_nettype none
module cid_alu (
  input  wire cid_pkg::cid_op_e    op_in,
  input  wire logic                byte_in,
  input  wire logic [15:0]         src_in,
  input  wire logic [15:0]         dst_in,
  input  wire cid_pkg::cid_flags_s flags_in,
  output logic [15:0]              res_out,
  output cid_pkg::cid_flags_s      flags_out,
  output logic                     dst_wr_out,
  output logic                     flag_wr_out
);
  import cid_pkg::*;
  logic [15:0] mask_w, sm_w, dm_w, bm_w, r;
  logic        inv_w, cin_w, sum_c_w, sum_v_w, c_o, v_o, bcd_c;
  logic [16:0] sum_w;
  logic [15:0] bcd_r;
  logic [4:0]  dig;

  function automatic logic top(input logic [15:0] x, input logic b);
    top = b ? x[7] : x[15];
  endfunction

  // one adder serves sums, differences and compare
  assign mask_w  = byte_in ? 16'h00ff : 16'hffff;
  assign sm_w    = src_in & mask_w;
  assign dm_w    = dst_in & mask_w;
  assign inv_w   = op_in inside {difference_with_borrow_op, difference_op, compare_op};
  assign bm_w    = (inv_w ? ~src_in : src_in) & mask_w;
  // carry in: one for difference, old carry for borrow
  assign cin_w   = (op_in inside {difference_op, compare_op}) ? 1'b1 :
                   (op_in inside {sum_with_carry_op, difference_with_borrow_op}) ? flags_in.c : 1'b0;
  assign sum_w   = {1'b0, dm_w} + {1'b0, bm_w} + {16'h0000, cin_w};
  assign sum_c_w = byte_in ? sum_w[8] : sum_w[16];
  assign sum_v_w = (top(dm_w, byte_in) == top(bm_w, byte_in)) &&
                   (top(sum_w[15:0], byte_in) != top(dm_w, byte_in));

  // packed bcd, digit by digit; a byte stops after two digits
  always_comb begin
    bcd_r = 16'h0000;
    bcd_c = flags_in.c;
    dig   = 5'h00;
    for (int i = 0; i < 4; i++) begin
      if (!byte_in || i < 2) begin
        dig = {1'b0, dm_w[4*i +: 4]} + {1'b0, sm_w[4*i +: 4]} + {4'h0, bcd_c};
        bcd_c = dig > 5'h09;
        if (bcd_c) begin
          dig = dig + 5'h06;
        end
        bcd_r[4*i +: 4] = dig[3:0];
      end
    end
  end

  // result select and flag policy per operation
  always_comb begin
    r = dm_w;
    c_o = 1'b0;
    v_o = 1'b0;
    dst_wr_out = 1'b1;
    flag_wr_out = 1'b1;
    unique case (op_in)
      copy_op: begin
        r = sm_w;
        flag_wr_out = 1'b0;
      end
      sum_op, sum_with_carry_op, difference_with_borrow_op, difference_op: begin
        r = sum_w[15:0] & mask_w;
        c_o = sum_c_w;
        v_o = sum_v_w;
      end
      compare_op: begin
        r = sum_w[15:0] & mask_w;
        c_o = sum_c_w;
        v_o = sum_v_w;
        dst_wr_out = 1'b0;
      end
      decimal_sum_op: begin
        r = bcd_r;
        c_o = bcd_c;
      end
      mask_test_op, and_op: begin
        r = sm_w & dm_w;
        c_o = (r != 16'h0000);
        dst_wr_out = (op_in == and_op);
      end
      mask_clear_op: begin
        r = ~sm_w & dm_w;
        flag_wr_out = 1'b0;
      end
      mask_set_op: begin
        r = sm_w | dm_w;
        flag_wr_out = 1'b0;
      end
      xor_op: begin
        r = sm_w ^ dm_w;
        c_o = (r != 16'h0000);
        v_o = top(sm_w, byte_in) & top(dm_w, byte_in);
      end
      // old carry enters at the top
      rotate_right_carry_op: begin
        r = byte_in ? {8'h00, flags_in.c, dm_w[7:1]} : {flags_in.c, dm_w[15:1]};
        c_o = dm_w[0];
      end
      shift_right_signed_op: begin
        r = byte_in ? {8'h00, dm_w[7], dm_w[7:1]} : {dm_w[15], dm_w[15:1]};
        c_o = dm_w[0];
      end
      byte_swap_op: begin
        r = {dst_in[7:0], dst_in[15:8]};
        flag_wr_out = 1'b0;
      end
      sign_extend_op: begin
        r = {{8{dst_in[7]}}, dst_in[7:0]};
        c_o = (r != 16'h0000);
      end
      default: begin
        dst_wr_out = 1'b0;
        flag_wr_out = 1'b0;
      end
    endcase
  end

  assign res_out   = r;
  assign flags_out = '{v: v_o, n: top(r, byte_in), z: (r == 16'h0000), c: c_o};
endmodule
`default_nettype wire

// [design/cid_decode.sv]
// instruction decode and execute sequencer with stack memory access
`include "cid_cfg.svh"
`default_nettype none
module cid_decode (
  input  wire logic                  clk_sys_in,
  input  wire logic                  sys_rst_in,
  input  wire cid_pkg::cid_issue_s   issue_in,
  output logic                       ready_out,
  output cid_pkg::cid_mem_req_s      mem_out,
  input  wire cid_pkg::cid_mem_rsp_s mem_in,
  output cid_pkg::cid_result_s       res_out
);
  import cid_pkg::*;

  logic [15:0]  ins_w, cg_val_w, src_w, opnd_w, jofs_w, jtarget_w, alu_res;
  logic [3:0]   opc_w, sreg_w, dreg_w, sgl_sel_w, cg_reg_w;
  logic [1:0]   as_w;
  logic [2:0]   jcond_w, cyc_w, src_cyc_w, stk_cyc_w, sgl_cyc_w;
  logic [7:0]   cond_vec_w;
  logic         ad_w, is_dual, is_jump, is_sgl, byte_op_w, cg_hit_w, src_reg_w;
  logic         jtaken_w, take_w, alu_dst_wr, alu_flag_wr;
  cid_op_e      op_w, sgl_op_w;
  cid_flags_s   alu_flags;
  cid_state_e   state_q, state_d;
  cid_result_s  res_q, res_d, issue_res_w;
  cid_mem_req_s mem_q, mem_d, issue_mem_w;

  // field extraction
  assign ins_w     = issue_in.instr;
  assign opc_w     = ins_w[15:12];
  assign sreg_w    = ins_w[`CID_SREG_LO +: 4];
  assign dreg_w    = ins_w[`CID_DREG_LO +: 4];
  assign ad_w      = ins_w[`CID_AD_BIT];
  assign as_w      = ins_w[`CID_AS_LO +: 2];
  assign sgl_sel_w = ins_w[`CID_SGL_SEL_LO +: 4];
  assign jcond_w   = ins_w[`CID_JCOND_LO +: 3];

  assign is_dual = (opc_w >= `CID_DUAL_MIN);
  assign is_jump = (ins_w[15:13] == `CID_JUMP_TAG);
  assign is_sgl  = (ins_w[15:10] == `CID_SGL_TAG);

  // single-operand selector; unused selector codes are illegal
  always_comb begin
    unique case (sgl_sel_w)
      4'h0, 4'h1: sgl_op_w = rotate_right_carry_op;
      4'h2:       sgl_op_w = byte_swap_op;
      4'h4, 4'h5: sgl_op_w = shift_right_signed_op;
      4'h6:       sgl_op_w = sign_extend_op;
      4'h8, 4'h9: sgl_op_w = push_op;
      4'ha:       sgl_op_w = call_op;
      4'hc:       sgl_op_w = interrupt_return_op;
      default:    sgl_op_w = illegal_op;
    endcase
  end

  // dual code minus four is the operation index
  // anything unmatched becomes the illegal operation
  assign op_w = is_dual ? cid_op_e'({1'b0, 4'(opc_w - `CID_DUAL_MIN)}) :
                is_jump ? jump_op : is_sgl ? sgl_op_w : illegal_op;

  // byte select only where the format defines it
  assign byte_op_w = ins_w[`CID_BW_BIT] &&
                     (is_dual || (op_w inside {rotate_right_carry_op,
                                               shift_right_signed_op, push_op}));

  // constant generator on r3 any mode, r2 indirect modes
  assign cg_reg_w = is_dual ? sreg_w : dreg_w;
  assign cg_hit_w = (is_dual || is_sgl) &&
                    (cg_reg_w == `CID_REG_CG2 || (cg_reg_w == `CID_REG_SR && as_w[1]));
  assign cg_val_w = (cg_reg_w == `CID_REG_SR) ? (as_w[0] ? `CID_CG_EIGHT : `CID_CG_FOUR) :
                    (as_w == 2'h0) ? `CID_CG_ZERO : (as_w == 2'h1) ? `CID_CG_ONE :
                    (as_w == 2'h2) ? `CID_CG_TWO : `CID_CG_ONES;
  assign src_w    = (is_dual && cg_hit_w) ? cg_val_w : issue_in.src_val;
  assign opnd_w   = (is_sgl && cg_hit_w) ? cg_val_w : issue_in.dst_val;

  // condition table indexed by selector, last entry always true
  assign cond_vec_w = {1'b1,
                       issue_in.flags.n != issue_in.flags.v,
                       issue_in.flags.n == issue_in.flags.v,
                       issue_in.flags.n, issue_in.flags.c, !issue_in.flags.c,
                       issue_in.flags.z, !issue_in.flags.z};
  assign jtaken_w   = cond_vec_w[jcond_w];
  // sign extend the offset and shift it left once
  assign jofs_w     = {{5{ins_w[`CID_JOFS_MSB]}}, ins_w[`CID_JOFS_MSB:0], 1'b0};
  // target is the current pc plus doubled offset
  assign jtarget_w  = issue_in.pc + jofs_w;

  // source mode 00 register, 01 indexed, 1x indirect
  assign src_reg_w = (as_w == 2'h0) || cg_hit_w;
  // source class sets the base count
  assign src_cyc_w = src_reg_w ? `CID_CYC_SRC_REG :
                     (as_w == 2'h1) ? `CID_CYC_SRC_IDX : `CID_CYC_SRC_IND;
  assign stk_cyc_w = src_reg_w ? `CID_CYC_STK_REG :
                     (as_w == 2'h1) ? `CID_CYC_STK_IDX : `CID_CYC_STK_IND;
  assign sgl_cyc_w = src_reg_w ? `CID_CYC_SGL_REG :
                     (as_w == 2'h1) ? `CID_CYC_SGL_IDX : `CID_CYC_SGL_IND;

  // cycle count per format; indexed destination costs more than a pc destination
  always_comb begin
    cyc_w = `CID_CYC_ILLEGAL;
    if (is_dual) begin
      // destination adds copy or alu penalty
      if (ad_w) begin
        cyc_w = 3'(src_cyc_w + ((op_w == copy_op) ? `CID_CYC_IDX_COPY : `CID_CYC_IDX_ALU));
      end else if (dreg_w == `CID_REG_PC) begin
        cyc_w = 3'(src_cyc_w + `CID_CYC_PC_EXTRA);
      end else begin
        cyc_w = src_cyc_w;
      end
    end else if (op_w == jump_op) begin
      cyc_w = `CID_CYC_JUMP;
    end else if (op_w == interrupt_return_op) begin
      cyc_w = `CID_CYC_INTERRUPT_RETURN_OP;
    end else if (op_w inside {push_op, call_op}) begin
      cyc_w = stk_cyc_w;
    end else if (op_w != illegal_op) begin
      cyc_w = sgl_cyc_w;
    end
  end

  // shared datapath for all dual and single operations
  cid_alu u_alu (
    .op_in       (op_w),
    .byte_in     (byte_op_w),
    .src_in      (src_w),
    .dst_in      (opnd_w),
    .flags_in    (issue_in.flags),
    .res_out     (alu_res),
    .flags_out   (alu_flags),
    .dst_wr_out  (alu_dst_wr),
    .flag_wr_out (alu_flag_wr)
  );

  assign ready_out = (state_q == st_idle);
  assign take_w    = issue_in.valid && ready_out;

  // completion record for the instruction being taken
  always_comb begin
    issue_res_w           = '0;
    issue_res_w.valid     = !(op_w inside {push_op, call_op, interrupt_return_op});
    issue_res_w.illegal   = (op_w == illegal_op);
    issue_res_w.byte_op   = byte_op_w;
    issue_res_w.src_const = cg_hit_w;
    issue_res_w.dst_wr    = alu_dst_wr;
    issue_res_w.dst_reg   = dreg_w;
    issue_res_w.result    = alu_res;
    issue_res_w.flag_wr   = alu_flag_wr;
    issue_res_w.flags     = alu_flags;
    issue_res_w.pc        = issue_in.pc;
    issue_res_w.sp        = issue_in.sp;
    issue_res_w.cycles    = cyc_w;
    // pc only moves when the condition holds
    if (op_w == jump_op) begin
      issue_res_w.pc_wr = jtaken_w;
      issue_res_w.pc    = jtaken_w ? jtarget_w : issue_in.pc;
    end
    if (op_w inside {push_op, call_op}) begin
      issue_res_w.sp_wr = 1'b1;
      issue_res_w.sp    = issue_in.sp - `CID_STACK_STEP;
    end
    // call then loads the operand into pc
    if (op_w == call_op) begin
      issue_res_w.pc_wr = 1'b1;
      issue_res_w.pc    = opnd_w;
    end
  end

  // first memory access of a stack operation
  always_comb begin
    issue_mem_w         = '0;
    issue_mem_w.req     = op_w inside {push_op, call_op, interrupt_return_op};
    issue_mem_w.we      = op_w inside {push_op, call_op};
    issue_mem_w.byte_op = byte_op_w;
    // first pop reads at the current sp
    issue_mem_w.addr    = (op_w == interrupt_return_op) ? issue_in.sp :
                          issue_in.sp - `CID_STACK_STEP;
    // the return pc is what goes on the stack for a call
    issue_mem_w.wdata   = (op_w == call_op) ? issue_in.pc :
                          (byte_op_w ? {8'h00, opnd_w[7:0]} : opnd_w);
  end

  // sequencer: a request stays up until acknowledged
  always_comb begin
    state_d     = state_q;
    res_d       = res_q;
    res_d.valid = 1'b0;
    mem_d       = mem_q;
    unique case (state_q)
      st_idle: begin
        if (take_w) begin
          res_d   = issue_res_w;
          mem_d   = issue_mem_w;
          state_d = (op_w == interrupt_return_op) ? st_pop_status :
                    (op_w inside {push_op, call_op}) ? st_store : st_idle;
        end
      end
      st_store: begin
        if (mem_in.ack) begin
          mem_d.req   = 1'b0;
          res_d.valid = 1'b1;
          state_d     = st_idle;
        end
      end
      // status word first; it restores all four flags
      st_pop_status: begin
        if (mem_in.ack) begin
          res_d.sr      = mem_in.rdata;
          res_d.sr_wr   = 1'b1;
          res_d.flag_wr = 1'b1;
          res_d.flags   = '{v: mem_in.rdata[`CID_SR_V], n: mem_in.rdata[`CID_SR_N],
                            z: mem_in.rdata[`CID_SR_Z], c: mem_in.rdata[`CID_SR_C]};
          mem_d.addr    = mem_q.addr + `CID_STACK_STEP;
          state_d       = st_pop_pc;
        end
      end
      // then pc, with post-increment of sp
      st_pop_pc: begin
        if (mem_in.ack) begin
          mem_d.req   = 1'b0;
          res_d.pc    = mem_in.rdata;
          res_d.pc_wr = 1'b1;
          res_d.sp_wr = 1'b1;
          res_d.sp    = mem_q.addr + `CID_STACK_STEP;
          res_d.valid = 1'b1;
          state_d     = st_idle;
        end
      end
    endcase
  end

  // state and registered outputs
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= st_idle;
      res_q   <= '0;
      mem_q   <= '0;
    end else begin
      state_q <= state_d;
      res_q   <= res_d;
      mem_q   <= mem_d;
    end
  end

  assign mem_out = mem_q;
  assign res_out = res_q;

  // checks on the decode and sequencing behaviour
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  property p_jump_target;
    take_w && is_jump && jtaken_w |=> res_out.valid && res_out.pc_wr &&
      (res_out.pc - $past(issue_in.pc)) ==
      {{5{$past(ins_w[9])}}, $past(ins_w[9:0]), 1'b0};
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

  property p_jump_flags;
    take_w && is_jump |=> res_out.valid && !res_out.flag_wr && !res_out.dst_wr;
  endproperty
  a_jump_flags: assert property (p_jump_flags) else $error("jump touched flags");

  property p_byte_width;
    take_w && is_dual && ins_w[6] |=> res_out.byte_op && res_out.result[15:8] == 8'h00;
  endproperty
  a_byte_width: assert property (p_byte_width) else $error("byte result wide");

  property p_compare;
    take_w && op_w == compare_op |=> !res_out.dst_wr && res_out.flag_wr;
  endproperty
  a_compare: assert property (p_compare) else $error("compare wrote dst");

  property p_mask_test;
    take_w && op_w == mask_test_op |=> !res_out.dst_wr && res_out.flag_wr && !res_out.flags.v;
  endproperty
  a_mask_test: assert property (p_mask_test) else $error("mask test wrong");

  property p_flag_keep;
    take_w && (op_w inside {copy_op, mask_clear_op, mask_set_op}) |=>
      res_out.dst_wr && !res_out.flag_wr;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flags changed");

  property p_push_sp;
    take_w && op_w == push_op |=> mem_out.req && mem_out.we &&
      mem_out.addr == $past(issue_in.sp) - 16'h0002;
  endproperty
  a_push_sp: assert property (p_push_sp) else $error("push address wrong");

  property p_interrupt_return_op_order;
    take_w && op_w == interrupt_return_op |=> mem_out.req && !mem_out.we &&
      mem_out.addr == $past(issue_in.sp) && state_q == st_pop_status;
  endproperty
  a_interrupt_return_op_order: assert property (p_interrupt_return_op_order) else $error("interrupt_return_op pop order");

  property p_reg_cycles;
    take_w && is_dual && as_w == 2'h0 && !ad_w && sreg_w > 4'h3 && dreg_w != 4'h0
      |=> res_out.cycles == 3'h1;
  endproperty
  a_reg_cycles: assert property (p_reg_cycles) else $error("cycle count wrong");

  property p_illegal;
    take_w && op_w == illegal_op |=> res_out.valid && res_out.illegal &&
      !res_out.dst_wr && !res_out.pc_wr && !res_out.flag_wr ##1 (!res_out.valid || $past(take_w));
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal not flagged");

  property p_negative;
    res_out.valid && res_out.flag_wr && !res_out.sr_wr |->
      res_out.flags.n == (res_out.byte_op ? res_out.result[7] : res_out.result[15]);
  endproperty
  a_negative: assert property (p_negative) else $error("negative flag wrong");

  c_jump_taken: cover property (take_w && is_jump && jtaken_w);
  c_interrupt_return_op_done:  cover property (state_q == st_pop_pc && mem_in.ack);
  c_call_done:  cover property (state_q == st_store && mem_in.ack);
  c_illegal:    cover property (take_w && op_w == illegal_op);
endmodule
`default_nettype wire

// [verification/cid_mem_model.sv]
// memory bus partner: small word store answering each request after a set wait
`default_nettype none
module cid_mem_model (
  input  wire logic                  clk_sys_in,
  input  wire logic                  sys_rst_in,
  input  wire cid_pkg::cid_mem_req_s req_in,
  input  wire logic [3:0]            wait_in,
  output var  cid_pkg::cid_mem_rsp_s rsp_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import cid_pkg::*;
  logic [15:0] mem_q [16];
  logic [3:0]  cnt_q;
  // one-cycle ack once the wait has run out; only 16 words, so addresses alias
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_q   <= 4'h0;
      rsp_out <= '0;
    end else if (req_in.req && !rsp_out.ack && cnt_q >= wait_in) begin
      cnt_q         <= 4'h0;
      rsp_out.ack   <= 1'b1;
      rsp_out.rdata <= mem_q[req_in.addr[4:1]];
      if (req_in.we) begin
        mem_q[req_in.addr[4:1]] <= req_in.wdata;
      end
    end else begin
      // stale read data flips so a late sample never matches by luck
      cnt_q         <= req_in.req ? cnt_q + 4'h1 : 4'h0;
      rsp_out.ack   <= 1'b0;
      rsp_out.rdata <= ~rsp_out.rdata;
    end
  end
endmodule
`default_nettype wire

// [verification/cid_decode_tb.sv]
// self-checking bench for the instruction decode and execute block
`default_nettype none
module cid_decode_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cid_pkg::*;
  logic         clk_sys_in;
  logic         sys_rst_in;
  logic         ready;
  logic [3:0]   mem_wait;
  logic [15:0]  ma;
  logic [15:0]  mw;
  cid_issue_s   iss;
  cid_mem_req_s mreq;
  cid_mem_rsp_s mrsp;
  cid_result_s  res;
  int           fails = 0;
  int           num_checks = 0;
  int           cyc = 0;
  cid_decode u_cid_decode (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .issue_in(iss),
    .ready_out(ready), .mem_out(mreq), .mem_in(mrsp), .res_out(res));
  cid_mem_model u_cid_mem_model (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .req_in(mreq), .wait_in(mem_wait), .rsp_out(mrsp));
  // 40 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // hang guard: the run needs about 120 cycles
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // offer one instruction while idle, then wait bounded for completion
  task automatic run(input logic [15:0] ins, s, d, input logic [3:0] f,
                     input logic [15:0] sp, pc);
    // a fresh edge first, so valid never falls and rises in one time step
    @(posedge clk_sys_in);
    #1 iss = {1'b1, ins, pc, sp, s, d, f};
    @(posedge clk_sys_in);
    #1 iss.valid = 1'b0;
    for (int n = 0; n < 40 && res.valid !== 1'b1; n++) begin
      if (mreq.req === 1'b1) {ma, mw} = {mreq.addr, mreq.wdata};
      @(posedge clk_sys_in);
      #1;
    end
    chk({15'h0, res.valid}, 16'h1);
  endtask
  // w = {illegal, dst_wr, flag_wr}; flags judged only when loaded
  task automatic a(input logic [15:0] ins, s, d, input logic [3:0] fi, input logic [15:0] r,
                   input logic [2:0] w, input logic [3:0] fo, input logic [2:0] cy);
    run(ins, s, d, fi, 16'h0400, 16'h1000);
    chk({13'h0, res.illegal, res.dst_wr, res.flag_wr}, {13'h0, w});
    if (w[1]) chk(res.result, r);
    if (w[0]) chk({12'h0, res.flags}, {12'h0, fo});
    chk({13'h0, res.cycles}, {13'h0, cy});
  endtask
  // every jump condition, forward and backward offsets; z stays clear, so selectors 0 and 1 are each seen only taken or only not taken
  task automatic jumps();
    logic [3:0] f;
    logic       t;
    for (int i = 0; i < 16; i++) begin
      f = i[3] ? 4'h5 : 4'h0;
      case (i[2:0])
        3'h0: t = ~f[1];
        3'h1: t = f[1];
        3'h2: t = ~f[0];
        3'h3: t = f[0];
        3'h4: t = f[2];
        3'h5: t = f[2] ~^ f[3];
        3'h6: t = f[2] ^ f[3];
        default: t = 1'b1;
      endcase
      run({3'h1, i[2:0], i[3] ? 10'h3fe : 10'h005}, 16'h0, 16'h0, f, 16'h0400, 16'h1000);
      chk({14'h0, res.pc_wr, res.flag_wr}, {14'h0, t, 1'b0});
      if (t) chk(res.pc, i[3] ? 16'h0ffc : 16'h100a);
      chk({13'h0, res.cycles}, 16'h2);
    end
  endtask
  // two pushes build a frame that the interrupt return reads back on a slow bus
  task automatic stack();
    mem_wait = 4'h0;
    run(16'h1205, 16'h2468, 16'h2468, 4'h0, 16'h0404, 16'h1000);
    chk(ma, 16'h0402);
    chk(mw, 16'h2468);
    chk(res.sp, 16'h0402);
    run(16'h1205, 16'h0105, 16'h0105, 4'h0, 16'h0402, 16'h1000);
    chk({13'h0, res.cycles}, 16'h3);
    mem_wait = 4'h3;
    run(16'h1285, 16'h3000, 16'h3000, 4'h0, 16'h0500, 16'h2000);
    chk(ma, 16'h04fe);
    chk(mw, 16'h2000);
    chk(res.pc, 16'h3000);
    run(16'h1300, 16'h0, 16'h0, 4'h0, 16'h0400, 16'h1000);
    chk({12'h0, res.sr_wr, res.flag_wr, res.pc_wr, res.sp_wr}, 16'hf);
    chk(res.sr, 16'h0105);
    chk({12'h0, res.flags}, 16'hd);
    chk(res.pc, 16'h2468);
    chk(res.sp, 16'h0404);
  endtask
  initial begin
    iss = '0;
    mem_wait = 4'h0;
    sys_rst_in = 1'b1;
    repeat (10) @(posedge clk_sys_in);
    #1 sys_rst_in = 1'b0;
    chk({15'h0, ready}, 16'h1);
    a(16'h8405, 16'h1, 16'h1, 4'h0, 16'h0, 3'h3, 4'h3, 3'h1);
    a(16'h7405, 16'h1, 16'h8000, 4'h0, 16'h7ffe, 3'h3, 4'h9, 3'h1);
    a(16'hf445, 16'hf0, 16'h1290, 4'h8, 16'h90, 3'h3, 4'h5, 3'h1);
    chk({15'h0, res.byte_op}, 16'h1);
    a(16'hc405, 16'hff, 16'h1234, 4'hf, 16'h1200, 3'h2, 4'h0, 3'h1);
    a(16'hd405, 16'h1, 16'h1230, 4'hf, 16'h1231, 3'h2, 4'h0, 3'h1);
    a(16'hb405, 16'h8000, 16'h8001, 4'h0, 16'h0, 3'h1, 4'h5, 3'h1);
    a(16'h9405, 16'h2, 16'h1, 4'h0, 16'h0, 3'h1, 4'h4, 3'h1);
    a(16'he405, 16'h8001, 16'h8000, 4'h0, 16'h1, 3'h3, 4'h9, 3'h1);
    a(16'ha405, 16'h19, 16'h1, 4'h9, 16'h21, 3'h3, 4'h0, 3'h1);
    a(16'h5405, 16'h7fff, 16'h1, 4'h0, 16'h8000, 3'h3, 4'hc, 3'h1);
    a(16'h6405, 16'h1, 16'h1, 4'h1, 16'h3, 3'h3, 4'h0, 3'h1);
    a(16'h1005, 16'h0, 16'h2, 4'h1, 16'h8001, 3'h3, 4'h4, 3'h1);
    a(16'h1105, 16'h0, 16'h8003, 4'h0, 16'hc001, 3'h3, 4'h5, 3'h1);
    a(16'h1085, 16'h0, 16'h1234, 4'h0, 16'h3412, 3'h2, 4'h0, 3'h1);
    a(16'h1185, 16'h0, 16'h0080, 4'h0, 16'hff80, 3'h3, 4'h5, 3'h1);
    a(16'h4400, 16'h1, 16'h1, 4'h0, 16'h1, 3'h2, 4'h0, 3'h2);
    a(16'h5485, 16'h1, 16'h1, 4'h0, 16'h2, 3'h3, 4'h0, 3'h4);
    a(16'h54a5, 16'h1, 16'h1, 4'h0, 16'h2, 3'h3, 4'h0, 3'h5);
    a(16'h4435, 16'h77, 16'h1, 4'h0, 16'h77, 3'h2, 4'h0, 3'h2);
    a(16'h4420, 16'h9, 16'h1, 4'h0, 16'h9, 3'h2, 4'h0, 3'h3);
    a(16'h4415, 16'h5, 16'h1, 4'h0, 16'h5, 3'h2, 4'h0, 3'h3);
    a(16'h5495, 16'h1, 16'h1, 4'h0, 16'h2, 3'h3, 4'h0, 3'h6);
    a(16'h4335, 16'h0, 16'h0, 4'h0, 16'hffff, 3'h2, 4'h0, 3'h1);
    a(16'h4225, 16'h0, 16'h0, 4'h0, 16'h0004, 3'h2, 4'h0, 3'h1);
    chk({15'h0, res.src_const}, 16'h1);
    a(16'h4235, 16'h0, 16'h0, 4'h0, 16'h0008, 3'h2, 4'h0, 3'h1);
    a(16'h0000, 16'h1, 16'h1, 4'h0, 16'h0, 3'h4, 4'h0, 3'h1);
    jumps();
    stack();
    end_sim();
  end
endmodule
`default_nettype wire
